// ===== rtl/dbsp_pkg.sv
// shared constants of the double-rate burst-of-four memory port
// assumes both ends run on one core clock and meet through dbsp_link_if
package dbsp_pkg;
  localparam int ADDR_W      = 8;   // word lines of the model memory
  localparam int DATA_W      = 36;
  localparam int BYTE_W      = 9;   // bits covered by one byte mask
  localparam int MASK_W      = 4;
  localparam int BURST_LEN   = 4;   // fixed burst, beats per transfer
  localparam int BEAT_IDX_W  = 2;
  localparam int DIV_HALF    = 4;   // core cycles per link clock half period
  localparam int DIV_W       = 3;
  localparam int RD_LAT_CYC  = 2;   // read latency in link clock cycles
  typedef enum logic [1:0] {
    DBSP_LH_IDLE = 2'b00,
    DBSP_LH_RD   = 2'b01,
    DBSP_LH_WR   = 2'b10
  } dbsp_slot_t;
endpackage : dbsp_pkg

// ===== rtl/dbsp_link_if.sv
// link between the memory controller end and the memory end
// assumes the controller makes the link clock pair
`timescale 1ns/10ps
interface dbsp_link_if;
  logic                        in_clk_true;
  logic                        in_clk_inv;
  logic                        rd_sel_n;
  logic                        wr_sel_n;
  logic [dbsp_pkg::ADDR_W-1:0] memory_location_lines;
  logic [dbsp_pkg::DATA_W-1:0] wr_data;
  logic [dbsp_pkg::MASK_W-1:0] byte_write_mask_n;
  logic [dbsp_pkg::DATA_W-1:0] rd_data;
  logic                        echo_timing_true;
  logic                        echo_timing_inverted;
  logic                        output_beat_valid;
  modport ctrl (output in_clk_true, in_clk_inv, rd_sel_n, wr_sel_n, memory_location_lines,
                wr_data, byte_write_mask_n,
                input rd_data, echo_timing_true, echo_timing_inverted, output_beat_valid);
  modport mem (input in_clk_true, in_clk_inv, rd_sel_n, wr_sel_n, memory_location_lines,
               wr_data, byte_write_mask_n,
               output rd_data, echo_timing_true, echo_timing_inverted, output_beat_valid);
endinterface : dbsp_link_if

// ===== rtl/dbsp_mem_end.sv
// memory end: double-rate burst-of-four static memory with late write
// assumes link clocks come from another domain; they are synchronised and edge detected
`timescale 1ns/10ps
module dbsp_mem_end #(
  parameter int DEPTH = 1 << dbsp_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // link
  dbsp_link_if.mem  lnk,
  // user side status
  output logic      wr_done,
  output logic      rd_busy
);
  localparam int AW = dbsp_pkg::ADDR_W;
  localparam int DW = dbsp_pkg::DATA_W;
  localparam int MW = dbsp_pkg::MASK_W;
  localparam int BW = dbsp_pkg::BYTE_W;

  // storage, four words per burst location
  logic [DW-1:0] mem_q [0:DEPTH*dbsp_pkg::BURST_LEN-1];

  // two-flop synchronisers for the link clocks
  logic [1:0] kt_sync_r;
  logic [1:0] kc_sync_r;
  logic       kt_prev_r;
  logic       kc_prev_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      kt_sync_r <= 2'h0;
      kc_sync_r <= 2'h3;  // complement idles high, no false edge after reset
      kt_prev_r <= 1'b0;
      kc_prev_r <= 1'b1;
    end else begin
      kt_sync_r <= {kt_sync_r[0], lnk.in_clk_true};
      kc_sync_r <= {kc_sync_r[0], lnk.in_clk_inv};
      kt_prev_r <= kt_sync_r[1];
      kc_prev_r <= kc_sync_r[1];
    end
  end
  // rising edges only, never falling
  wire t_rise = kt_sync_r[1] & ~kt_prev_r;
  wire c_rise = kc_sync_r[1] & ~kc_prev_r;

  // data inputs are settled when the clock edge is seen; controller holds the command a whole link period, each write beat half of one
  wire          rd_req = ~lnk.rd_sel_n;
  wire          wr_req = ~lnk.wr_sel_n;
  wire [AW-1:0] adr_in = lnk.memory_location_lines;

  // write pipeline: command, then four beats over the next cycle and a half
  logic          wr_cmd_r;                  // write command seen on last true edge
  logic [AW-1:0] wr_adr_r;
  logic [1:0]    wr_beat_r;                 // next beat index while collecting
  logic          wr_coll_r;
  logic [DW-1:0] wbuf_d [0:3];              // internal write buffer
  logic [MW-1:0] wbuf_m [0:3];
  logic          wbuf_full_r;
  logic [AW-1:0] wbuf_adr_r;
  wire           beat_edge = t_rise | c_rise;
  wire           wr_last = wr_coll_r & c_rise & (wr_beat_r == 2'h3);

  // merge function: unmasked bytes from new data (mask is active low)
  function automatic logic [DW-1:0] merge_bytes(input logic [DW-1:0] old_w, input logic [DW-1:0] new_w,
                                                 input logic [MW-1:0] m_n);
    logic [DW-1:0] r;
    r = old_w;
    for (int b = 0; b < MW; b++) begin
      if (!m_n[b]) r[b*BW +: BW] = new_w[b*BW +: BW];
    end
    return r;
  endfunction : merge_bytes

  // write command capture and beat collection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_cmd_r  <= 1'b0;
      wr_adr_r  <= '0;
      wr_coll_r <= 1'b0;
      wr_beat_r <= 2'h0;
      wr_done   <= 1'b0;
    end else begin
      wr_done <= wr_last;
      if (t_rise) begin
        wr_cmd_r <= wr_req & ~wr_coll_r;
        if (wr_req & ~wr_coll_r) wr_adr_r <= adr_in;
        if (wr_cmd_r) begin
          wr_coll_r <= 1'b1;
          wr_beat_r <= 2'h1;
        end else if (wr_coll_r && wr_beat_r == 2'h2) begin
          wr_beat_r <= 2'h3;                                      // beat 2 taken on true edge, beat 3 next
        end
      end else if (c_rise && wr_coll_r) begin
        if (wr_beat_r == 2'h1) wr_beat_r <= 2'h2;
        else if (wr_beat_r == 2'h3) wr_coll_r <= 1'b0;
      end
    end
  end

  // buffer filling on both edges, one beat per edge
  wire       take_beat = (t_rise & wr_cmd_r) | (wr_coll_r & beat_edge);
  wire [1:0] beat_idx  = (t_rise & wr_cmd_r) ? 2'h0 : wr_beat_r;
  always_ff @(posedge core_clk) begin
    if (take_beat) begin
      wbuf_d[beat_idx] <= lnk.wr_data;
      wbuf_m[beat_idx] <= lnk.byte_write_mask_n;
    end
  end

  // commit buffered burst to the array on the next true edge after the last beat
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbuf_full_r <= 1'b0;
      wbuf_adr_r  <= '0;
    end else if (wr_last) begin
      wbuf_full_r <= 1'b1;
      wbuf_adr_r  <= wr_adr_r;
    end else if (t_rise) begin
      wbuf_full_r <= 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (wbuf_full_r && t_rise) begin
      for (int i = 0; i < dbsp_pkg::BURST_LEN; i++) begin
        mem_q[{wbuf_adr_r, i[1:0]}] <= merge_bytes(mem_q[{wbuf_adr_r, i[1:0]}], wbuf_d[i], wbuf_m[i]);
      end
    end
  end

  // read pipeline: command, one empty cycle, then two cycles of output
  logic          rd_cmd_r;
  logic [AW-1:0] rd_adr_r;
  logic [DW-1:0] rd_words [0:3];
  logic [2:0]    rd_ph_r;                   // 0 idle, 1 waiting, 2..5 beats 1..4
  wire  [AW-1:0] rd_adr_sel = rd_adr_r;
  // phase decode: no read in flight
  wire           rd_idle    = (rd_ph_r == 3'h0);
  // newest data: buffered write wins over array
  function automatic logic [DW-1:0] fetch(input logic [AW-1:0] a, input logic [1:0] i);
    logic [DW-1:0] w;
    w = mem_q[{a, i}];
    if (wbuf_full_r && wbuf_adr_r == a) w = merge_bytes(w, wbuf_d[i], wbuf_m[i]);
    return w;
  endfunction : fetch

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_cmd_r <= 1'b0;
      rd_adr_r <= '0;
      rd_ph_r  <= 3'h0;
      rd_busy  <= 1'b0;
    end else begin
      rd_busy <= ~rd_idle;
      if (t_rise) begin
        rd_cmd_r <= rd_req & (rd_ph_r == 3'h0 || rd_ph_r == 3'h5);
        if (rd_req) rd_adr_r <= adr_in;
        if (rd_cmd_r) rd_ph_r <= 3'h1;
        else if (rd_ph_r == 3'h1) rd_ph_r <= 3'h2;                  // third true edge
        else if (rd_ph_r == 3'h3) rd_ph_r <= 3'h4;                  // fourth true edge
        else if (rd_ph_r == 3'h5) rd_ph_r <= 3'h0;
      end else if (c_rise) begin
        if (rd_ph_r == 3'h2) rd_ph_r <= 3'h3;
        else if (rd_ph_r == 3'h4) rd_ph_r <= 3'h5;
      end
    end
  end
  // snapshot the burst two link cycles after the command, includes the buffer
  always_ff @(posedge core_clk) begin
    if (t_rise && rd_ph_r == 3'h1) begin
      for (int i = 0; i < dbsp_pkg::BURST_LEN; i++) rd_words[i] <= fetch(rd_adr_sel, i[1:0]);
    end
  end

  // output registers, echo clocks and valid
  wire       q_act = (rd_ph_r >= 3'h2) && (rd_ph_r <= 3'h5);
  wire [1:0] q_idx = 2'(rd_ph_r - 3'h2);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.rd_data              <= '0;
      lnk.output_beat_valid    <= 1'b0;
      lnk.echo_timing_true     <= 1'b0;
      lnk.echo_timing_inverted <= 1'b1;
    end else begin
      lnk.rd_data              <= q_act ? rd_words[q_idx] : '0;
      lnk.output_beat_valid    <= q_act;
      lnk.echo_timing_true     <= kt_sync_r[1];
      lnk.echo_timing_inverted <= kc_sync_r[1];
    end
  end
endmodule : dbsp_mem_end

// ===== rtl/dbsp_ctrl_end.sv
// controller end: makes the link clock pair, issues bursts of four
// assumes one user request of each kind at a time, held until accepted
`timescale 1ns/10ps
module dbsp_ctrl_end (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  // link
  dbsp_link_if.ctrl                        lnk,
  // user write request, four words and masks
  input  wire logic                        u_wr_req,
  input  wire logic [dbsp_pkg::ADDR_W-1:0] u_wr_adr,
  input  wire logic [4*dbsp_pkg::DATA_W-1:0] u_wr_data,
  input  wire logic [4*dbsp_pkg::MASK_W-1:0] u_wr_mask_n,
  output logic                             u_wr_ack,
  // user read request and returned words
  input  wire logic                        u_rd_req,
  input  wire logic [dbsp_pkg::ADDR_W-1:0] u_rd_adr,
  output logic                             u_rd_ack,
  output logic [4*dbsp_pkg::DATA_W-1:0]    u_rd_data,
  output logic                             u_rd_done
);
  localparam int DW = dbsp_pkg::DATA_W;
  localparam int MW = dbsp_pkg::MASK_W;

  // clock divider: link clock pair toggles every DIV_HALF core cycles
  logic [dbsp_pkg::DIV_W-1:0] div_r;
  wire  half_tick = (div_r == 3'(dbsp_pkg::DIV_HALF - 1));
  wire  rise_next = half_tick & ~lnk.in_clk_true;   // true clock about to rise
  wire  fall_next = half_tick &  lnk.in_clk_true;   // complement about to rise
  logic [1:0] slot_r;                               // alternate read and write slots
  logic       wr_pend_r;
  logic [2:0] wbeat_r;                              // next write beat 1..3, 4 idle
  logic [4*DW-1:0] wd_r;
  logic [4*MW-1:0] wm_r;
  dbsp_pkg::dbsp_slot_t slot_kind;

  // alternate slot kind so read and write addresses never share an edge
  assign slot_kind = slot_r[0] ? dbsp_pkg::DBSP_LH_WR : dbsp_pkg::DBSP_LH_RD;
  wire issue_rd = rise_next & (slot_kind == dbsp_pkg::DBSP_LH_RD) & u_rd_req;
  wire issue_wr = rise_next & (slot_kind == dbsp_pkg::DBSP_LH_WR) & u_wr_req & (wbeat_r == 3'h4);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r                     <= '0;
      lnk.in_clk_true           <= 1'b0;
      lnk.in_clk_inv            <= 1'b1;
      slot_r                    <= 2'h0;
      lnk.rd_sel_n              <= 1'b1;
      lnk.wr_sel_n              <= 1'b1;
      lnk.memory_location_lines <= '0;
      u_rd_ack                  <= 1'b0;
      u_wr_ack                  <= 1'b0;
    end else begin
      u_rd_ack <= issue_rd;
      u_wr_ack <= issue_wr;
      div_r    <= half_tick ? '0 : 3'(div_r + 3'h1);
      if (half_tick) begin
        lnk.in_clk_true <= ~lnk.in_clk_true;
        lnk.in_clk_inv  <= lnk.in_clk_true;
      end
      // command presented around the true rising edge, held one cycle
      if (rise_next) begin
        slot_r                    <= slot_r + 2'h1;
        lnk.rd_sel_n              <= ~issue_rd;
        lnk.wr_sel_n              <= ~issue_wr;
        lnk.memory_location_lines <= issue_rd ? u_rd_adr : u_wr_adr;
      end
    end
  end

  // write data: first beat one cycle after the command, then every half period
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbeat_r           <= 3'h4;
      wr_pend_r         <= 1'b0;
      wd_r              <= '0;
      wm_r              <= '1;
      lnk.wr_data       <= '0;
      lnk.byte_write_mask_n <= '1;
    end else begin
      if (issue_wr) begin
        wd_r      <= u_wr_data;
        wm_r      <= u_wr_mask_n;
        wr_pend_r <= 1'b1;
      end else if (rise_next && wr_pend_r) begin
        // first beat must stand at the true edge one link cycle after the command
        wr_pend_r             <= 1'b0;
        lnk.wr_data           <= wd_r[0 +: DW];
        lnk.byte_write_mask_n <= wm_r[0 +: MW];
        wbeat_r               <= 3'h1;
      end
      if (half_tick && wbeat_r != 3'h4) begin
        lnk.wr_data           <= wd_r[wbeat_r[1:0]*DW +: DW];
        lnk.byte_write_mask_n <= wm_r[wbeat_r[1:0]*MW +: MW];
        wbeat_r               <= (wbeat_r == 3'h3) ? 3'h4 : 3'(wbeat_r + 3'h1);
      end
    end
  end

  // read capture: first beat on the rise of valid, then one beat per link half period
  logic [1:0]                 rbeat_r;
  logic                       val_q_r;
  logic [dbsp_pkg::DIV_W-1:0] rcnt_r;
  wire  rd_first = lnk.output_beat_valid & ~val_q_r;
  wire  rd_next  = lnk.output_beat_valid & val_q_r & (rcnt_r == 3'(dbsp_pkg::DIV_HALF));
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rbeat_r   <= 2'h0;
      val_q_r   <= 1'b0;
      rcnt_r    <= '0;
      u_rd_data <= '0;
      u_rd_done <= 1'b0;
    end else begin
      val_q_r   <= lnk.output_beat_valid;
      u_rd_done <= 1'b0;
      if (rd_first) begin
        u_rd_data[0 +: DW] <= lnk.rd_data;
        rbeat_r            <= 2'h1;
        rcnt_r             <= 3'h1;
      end else if (rd_next) begin
        u_rd_data[rbeat_r*DW +: DW] <= lnk.rd_data;
        rbeat_r                     <= 2'(rbeat_r + 2'h1);
        rcnt_r                      <= 3'h1;
        u_rd_done                   <= (rbeat_r == 2'h3);
      end else if (val_q_r) begin
        rcnt_r <= 3'(rcnt_r + 3'h1);
      end
    end
  end
endmodule : dbsp_ctrl_end

// ===== verif/dbsp_asserts.sv
// link checker: timing relations between the controller end and the memory end
// assumes link clocks are made from core_clk and read beats last half a link cycle
`timescale 1ns/10ps
module dbsp_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link signals watched
  input wire logic in_clk_true,
  input wire logic in_clk_inv,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic output_beat_valid,
  input wire logic echo_timing_true,
  input wire logic echo_timing_inverted
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic       tru_d_r;
  logic       wr_prev_r;
  logic       rd_prev_r;
  logic [5:0] rd_age_r;
  logic [7:0] vld_run_r;
  // edge finding and command decode on the true link clock
  wire        tru_rise   = in_clk_true & ~tru_d_r;
  wire        rd_cmd     = tru_rise & ~rd_sel_n;
  wire        wr_cmd     = tru_rise & ~wr_sel_n;
  wire [5:0]  rd_age_nxt = rd_cmd ? 6'h00 : ((rd_age_r == 6'h3F) ? 6'h3F : rd_age_r + 6'h01);
  wire [7:0]  vld_run_nxt = output_beat_valid ? vld_run_r + 8'h01 : 8'h00;
  // history of the last command slot, age of last read, length of valid run
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tru_d_r   <= 1'b1;  // no false edge right after reset
      wr_prev_r <= 1'b0;
      rd_prev_r <= 1'b0;
      rd_age_r  <= 6'h3F;
      vld_run_r <= 8'h00;
    end else begin
      tru_d_r   <= in_clk_true;
      wr_prev_r <= tru_rise ? ~wr_sel_n : wr_prev_r;
      rd_prev_r <= tru_rise ? ~rd_sel_n : rd_prev_r;
      rd_age_r  <= rd_age_nxt;
      vld_run_r <= vld_run_nxt;
    end
  end
  sequence read_issued_s; rd_cmd; endsequence
  sequence beats_start_s; ##[12:28] output_beat_valid; endsequence
  clk_pair_a: assert property (in_clk_inv == !in_clk_true) else $error("link clocks not complementary");
  rdwr_alt_a: assert property (tru_rise |-> !(!rd_sel_n && !wr_sel_n)) else $error("read and write on one edge");
  wr_spacing_a: assert property (wr_cmd |-> !wr_prev_r) else $error("write slots too close");
  rd_spacing_a: assert property (rd_cmd |-> !rd_prev_r) else $error("read slots too close");
  rd_latency_a: assert property (read_issued_s |-> beats_start_s) else $error("read data late");
  valid_cause_a: assert property ($rose(output_beat_valid) |-> rd_age_r inside {[12:28]})
    else $error("valid without read");
  burst_len_a: assert property ($fell(output_beat_valid) |-> vld_run_r[3:0] == 4'h0)
    else $error("read burst not four beats");
  echo_pair_a: assert property (output_beat_valid |-> echo_timing_inverted != echo_timing_true)
    else $error("echo clocks not complementary");
  echo_half_a: assert property ($rose(echo_timing_true) && output_beat_valid |-> ##[3:5] $fell(echo_timing_true))
    else $error("echo half period wrong");
endmodule : dbsp_asserts

// ===== verif/ddr_burst4_sram_port_tb_top.sv
// bench: controller end and memory end joined by the link, driven on the user side
// assumes requests are held until acked and read words come with u_rd_done
`timescale 1ns/10ps
module ddr_burst4_sram_port_tb_top;
  localparam int AW = dbsp_pkg::ADDR_W;
  localparam int BW = 4*dbsp_pkg::DATA_W;
  localparam int MW = 4*dbsp_pkg::MASK_W;
  logic          core_clk;
  logic          rst_n;
  logic          u_wr_req, u_wr_ack, u_rd_req, u_rd_ack, u_rd_done;
  logic [AW-1:0] u_wr_adr, u_rd_adr;
  logic [BW-1:0] u_wr_data, u_rd_data;
  logic [MW-1:0] u_wr_mask_n;
  logic [BW-1:0] mem_m [256];
  int            errors, num_checks;
  dbsp_link_if lnk ();
  dbsp_ctrl_end u_dbsp_ctrl_end (.core_clk(core_clk), .rst_n(rst_n), .lnk(lnk), .u_wr_req(u_wr_req),
    .u_wr_adr(u_wr_adr), .u_wr_data(u_wr_data), .u_wr_mask_n(u_wr_mask_n), .u_wr_ack(u_wr_ack),
    .u_rd_req(u_rd_req), .u_rd_adr(u_rd_adr), .u_rd_ack(u_rd_ack), .u_rd_data(u_rd_data),
    .u_rd_done(u_rd_done));
  dbsp_mem_end u_dbsp_mem_end (.core_clk(core_clk), .rst_n(rst_n), .lnk(lnk), .wr_done(), .rd_busy());
  dbsp_asserts u_dbsp_asserts (.core_clk(core_clk), .rst_n(rst_n), .in_clk_true(lnk.in_clk_true),
    .in_clk_inv(lnk.in_clk_inv), .rd_sel_n(lnk.rd_sel_n), .wr_sel_n(lnk.wr_sel_n),
    .output_beat_valid(lnk.output_beat_valid), .echo_timing_true(lnk.echo_timing_true),
    .echo_timing_inverted(lnk.echo_timing_inverted));
  // core clock, 10 ns
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input logic [BW-1:0] seen, input logic [BW-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // sixteen bytes counting up from a seed
  function automatic logic [BW-1:0] pat(input logic [8:0] seed);
    for (int i = 0; i < 16; i++) pat[i*9 +: 9] = seed + 9'(i);
  endfunction : pat
  // write burst: model takes unmasked bytes, request held until ack
  task automatic do_wr(input logic [AW-1:0] adr, input logic [BW-1:0] dat, input logic [MW-1:0] msk);
    int n;
    for (int i = 0; i < MW; i++) if (!msk[i]) mem_m[adr][i*9 +: 9] = dat[i*9 +: 9];
    n = 0;
    u_wr_req    <= 1'b1;
    u_wr_adr    <= adr;
    u_wr_data   <= dat;
    u_wr_mask_n <= msk;
    do begin
      @(posedge core_clk);
      n++;
    end while (u_wr_ack !== 1'b1 && n < 300);
    u_wr_req <= 1'b0;
    check(BW'(u_wr_ack), BW'(1));
  endtask : do_wr
  // read burst: expectation fixed at issue, four words compared at done
  task automatic do_rd(input logic [AW-1:0] adr);
    logic [BW-1:0] exp;
    int n;
    exp = mem_m[adr];
    n = 0;
    u_rd_req <= 1'b1;
    u_rd_adr <= adr;
    do begin
      @(posedge core_clk);
      n++;
    end while (u_rd_ack !== 1'b1 && n < 300);
    u_rd_req <= 1'b0;
    while (u_rd_done !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    check(u_rd_data, exp);
  endtask : do_rd
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    u_wr_req = 1'b0;
    u_rd_req = 1'b0;
    u_wr_adr = '0;
    u_rd_adr = '0;
    u_wr_data = '0;
    u_wr_mask_n = '1;
    errors = 0;
    num_checks = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    // full bursts at both ends of the space, read straight after the write
    foreach (u_wr_adr[k]) begin
      do_wr(8'(1 << k) - 8'h01, pat(9'(k*16)), 16'h0000);
      do_rd(8'(1 << k) - 8'h01);
    end
    do_wr(8'hFF, pat(9'h0A5), 16'h0000);
    do_rd(8'hFF);
    // beat i writes only byte i, then a fully masked burst
    do_wr(8'h07, pat(9'h1C0), 16'h7BDE);
    do_rd(8'h07);
    do_wr(8'h00, pat(9'h155), 16'hFFFF);
    do_rd(8'h00);
    // write and read at once on different locations
    fork
      do_wr(8'h3F, pat(9'h0F0), 16'hA5C3);
      do_rd(8'h07);
    join
    // reads back to back
    do_rd(8'h3F);
    do_rd(8'hFF);
    do_rd(8'h00);
    repeat (40) @(posedge core_clk);
    report_and_stop();
  end
endmodule : ddr_burst4_sram_port_tb_top
